// ### hdl/vgamm_defines.vh
// Constants for the memory map and colour compare register block.
`ifndef VGAMM_DEFINES_VH
`define VGAMM_DEFINES_VH
`define VGAMM_IDX_MISC        8'h06
`define VGAMM_IDX_IGNORE      8'h07
`define VGAMM_IDX_WMASK       8'h08
`define VGAMM_MISC_RESET      4'h0
`define VGAMM_IGNORE_RESET    4'h0
`define VGAMM_WMASK_RESET     8'h00
`define VGAMM_MAP_LSB         2
`define VGAMM_MAP_MSB         3
`define VGAMM_CHAIN_BIT       1
`define VGAMM_GFX_BIT         0
`define VGAMM_MAP_ALL         2'h0
`define VGAMM_MAP_A           2'h1
`define VGAMM_MAP_B0          2'h2
`define VGAMM_MAP_B8          2'h3
`define VGAMM_SEG_A           4'ha
`define VGAMM_SEG_B           4'hb
`define VGAMM_ADDR_BIT15      15
`define VGAMM_ADDR_MSB        16
`define VGAMM_SEG_LSB         16
`define VGAMM_SEG_MSB         19
`define VGAMM_OFS_MSB         15
`define VGAMM_A0_BIT          0
`define VGAMM_PLANES_ALL      4'hf
`define VGAMM_PLANES_ODD      4'ha
`define VGAMM_PLANES_EVEN     4'h5
`define VGAMM_PIXELS          8
`endif

// ### hdl/vgamm_regs.v
// Memory map, chain odd/even, text/graphics and colour compare register block.
`timescale 1ns/1ns
`include "vgamm_defines.vh"
module vgamm_regs (
    // Clock and reset.
    input  wire        clk,
    input  wire        resetn,
    // Indexed I/O data port.
    input  wire [7:0]  reg_index,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    output reg         reg_hit,
    // Controls from the rest of the controller.
    input  wire        pci_mem_enable,
    input  wire        misc_output_ram_enable,
    input  wire        read_mode_one,
    input  wire [3:0]  color_compare_value,
    // CPU memory cycle address and plane read latches.
    input  wire        cpu_mem_valid,
    input  wire [19:0] cpu_addr,
    input  wire [7:0]  plane0_data,
    input  wire [7:0]  plane1_data,
    input  wire [7:0]  plane2_data,
    input  wire [7:0]  plane3_data,
    // Decode and compare results.
    output reg         fb_hit,
    output reg  [16:0] fb_offset,
    output reg  [3:0]  plane_enable,
    output reg  [7:0]  compare_result,
    output reg         graphics_mode,
    output reg  [1:0]  memory_map,
    output reg  [7:0]  pixel_write_mask
);

    // Register state.
    reg  [3:0] misc_graphics_control;
    reg  [3:0] color_plane_ignore;

    // Next values of the registered outputs.
    reg        next_fb_hit;
    reg [16:0] next_fb_offset;
    reg  [3:0] next_plane_enable;
    reg  [7:0] next_compare;
    reg  [7:0] next_rdata;
    reg        next_hit;
    reg  [3:0] compare_include;
    reg [16:0] linear_offset;
    integer    i;

    // Field views of the miscellaneous register and of the CPU address.
    wire [1:0] map_sel    = misc_graphics_control[`VGAMM_MAP_MSB:`VGAMM_MAP_LSB];
    wire       chain      = misc_graphics_control[`VGAMM_CHAIN_BIT];
    wire       gfx_sel    = misc_graphics_control[`VGAMM_GFX_BIT];
    wire [3:0] seg        = cpu_addr[`VGAMM_SEG_MSB:`VGAMM_SEG_LSB];
    wire       upper_half = cpu_addr[`VGAMM_ADDR_BIT15];
    wire       addr_low   = cpu_addr[`VGAMM_A0_BIT];

    // Write strobes of the three registers.
    wire       wr_misc    = reg_wr && (reg_index == `VGAMM_IDX_MISC);
    wire       wr_ignore  = reg_wr && (reg_index == `VGAMM_IDX_IGNORE);
    wire       wr_wmask   = reg_wr && (reg_index == `VGAMM_IDX_WMASK);

    // Frame buffer window test for one setting of the map field.
    function window_hit;
        input [1:0] map;
        input [3:0] segment;
        input       upper;
        begin
            case (map)
                `VGAMM_MAP_ALL:
                begin
                    window_hit = (segment == `VGAMM_SEG_A) || (segment == `VGAMM_SEG_B);
                end
                `VGAMM_MAP_A:
                begin
                    window_hit = (segment == `VGAMM_SEG_A);
                end
                `VGAMM_MAP_B0:
                begin
                    window_hit = (segment == `VGAMM_SEG_B) && !upper;
                end
                `VGAMM_MAP_B8:
                begin
                    window_hit = (segment == `VGAMM_SEG_B) && upper;
                end
                default:
                begin
                    window_hit = 1'b0;
                end
            endcase
        end
    endfunction

    // Planes reached by one CPU access.
    function [3:0] plane_select;
        input chained;
        input low_bit;
        begin
            if (!chained)
                plane_select = `VGAMM_PLANES_ALL;
            else if (low_bit)
                plane_select = `VGAMM_PLANES_ODD;
            else
                plane_select = `VGAMM_PLANES_EVEN;
        end
    endfunction

    // One pixel column matches when every included plane equals its compare bit.
    function pixel_match;
        input [3:0] planes;
        input [3:0] cmp;
        input [3:0] included;
        begin
            pixel_match = ~|((planes ^ cmp) & included);
        end
    endfunction

    // Window decode, offset formation and plane selection.
    always @*
    begin
        next_fb_hit = window_hit(map_sel, seg, upper_half)
                      && cpu_mem_valid && pci_mem_enable && misc_output_ram_enable;
        if (map_sel == `VGAMM_MAP_ALL)
            linear_offset = {(seg == `VGAMM_SEG_B), cpu_addr[`VGAMM_OFS_MSB:0]};
        else
            linear_offset = {1'b0, cpu_addr[`VGAMM_OFS_MSB:0]};
        // With chaining the lowest bit picks the plane pair, so its offset position reads zero.
        if (chain)
            next_fb_offset = {linear_offset[`VGAMM_ADDR_MSB:1], 1'b0};
        else
            next_fb_offset = linear_offset;
        next_plane_enable = plane_select(chain, addr_low);
    end

    // Colour compare across the eight pixels of the addressed byte.
    always @*
    begin
        if (read_mode_one)
            compare_include = color_plane_ignore;
        else
            compare_include = `VGAMM_PLANES_ALL;
        for (i = 0; i < `VGAMM_PIXELS; i = i + 1)
            next_compare[i] = pixel_match({plane3_data[i], plane2_data[i], plane1_data[i], plane0_data[i]},
                                          color_compare_value, compare_include);
    end

    // Register read mux; upper nibbles of the misc and ignore registers are reserved, the write mask reads all eight bits.
    always @*
    begin
        next_hit = 1'b1;
        case (reg_index)
            `VGAMM_IDX_MISC:
            begin
                next_rdata = {4'h0, misc_graphics_control};
            end
            `VGAMM_IDX_IGNORE:
            begin
                next_rdata = {4'h0, color_plane_ignore};
            end
            `VGAMM_IDX_WMASK:
            begin
                next_rdata = pixel_write_mask;
            end
            default:
            begin
                next_rdata = 8'h00;
                next_hit   = 1'b0;
            end
        endcase
    end

    // Register writes; writes to other indices are ignored.
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            misc_graphics_control <= `VGAMM_MISC_RESET;
            color_plane_ignore    <= `VGAMM_IGNORE_RESET;
            pixel_write_mask      <= `VGAMM_WMASK_RESET;
        end
        else
        begin
            if (wr_misc)
                misc_graphics_control <= reg_wdata[3:0];
            if (wr_ignore)
                color_plane_ignore <= reg_wdata[3:0];
            if (wr_wmask)
                pixel_write_mask <= reg_wdata;
        end
    end

    // Read answer; it stands until the next read.
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            reg_rdata <= 8'h00;
            reg_hit   <= 1'b0;
        end
        else if (reg_rd)
        begin
            reg_rdata <= next_rdata;
            reg_hit   <= next_hit;
        end
    end

    // Decode and compare results, refreshed every cycle.
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            fb_hit         <= 1'b0;
            fb_offset      <= 17'h00000;
            plane_enable   <= 4'h0;
            compare_result <= 8'h00;
            graphics_mode  <= 1'b0;
            memory_map     <= 2'h0;
        end
        else
        begin
            fb_hit         <= next_fb_hit;
            fb_offset      <= next_fb_offset;
            plane_enable   <= next_plane_enable;
            compare_result <= next_compare;
            graphics_mode  <= gfx_sel;
            memory_map     <= map_sel;
        end
    end

endmodule // vgamm_regs

// ### tb/vgamm_host.sv
// Host model on the indexed register port.
`timescale 1ns/1ns
module vgamm_host (
    input  wire       clk,
    input  wire [7:0] reg_rdata,
    output reg  [7:0] reg_index = 8'h0, reg_wdata = 8'h0,
    output reg        reg_wr = 1'b0, reg_rd = 1'b0
);
    task wr(input [7:0] i, d);
        @(posedge clk) #1 {reg_index, reg_wdata, reg_wr} = {i, d, 1'b1};
        @(posedge clk) #1 reg_wr = 1'b0;
    endtask
    task rd(input [7:0] i, output [7:0] d);
        @(posedge clk) #1 {reg_index, reg_rd} = {i, 1'b1};
        @(posedge clk) #1 reg_rd = 1'b0;
        d = reg_rdata;
    endtask
endmodule // vgamm_host

// ### tb/vgamm_props.sv
// Port assertions for the memory map block.
`timescale 1ns/1ns
module vgamm_props (
    input wire        clk, resetn, reg_wr, reg_rd, cpu_mem_valid, pci_mem_enable, misc_output_ram_enable,
    input wire        fb_hit, graphics_mode,
    input wire [7:0]  reg_index, reg_wdata, reg_rdata,
    input wire [19:0] cpu_addr,
    input wire [16:0] fb_offset,
    input wire [3:0]  plane_enable,
    input wire [1:0]  memory_map
);
    wire [1:0] m = memory_map;
    wire       w6 = reg_wr && reg_index == 8'h06;
    // The design decodes with the map field that memory_map shows one cycle later.
    function win_of(input [1:0] mm, input [19:0] a);
        win_of = mm == 2'h0 ? a[19:17] == 3'h5 : mm == 2'h1 ? a[19:16] == 4'ha : a[19:15] == {4'hb, mm[0]};
    endfunction
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    a_hit_exact: assert property (1 |=> fb_hit == (win_of(m, $past(cpu_addr)) && $past(cpu_mem_valid
        && pci_mem_enable && misc_output_ram_enable))) else $error("fb_hit");
    a_hit_top: assert property (fb_hit |-> $past(cpu_addr[19:17]) == 3'h5) else $error("window");
    a_plane_sel: assert property (1 |=> plane_enable == 4'hf
        || plane_enable == ($past(cpu_addr[0]) ? 4'ha : 4'h5)) else $error("plane_enable");
    a_plain_addr: assert property (fb_hit && plane_enable == 4'hf |-> fb_offset[0] == $past(cpu_addr[0]))
        else $error("fb_offset");
    a_chain_even: assert property (plane_enable != 4'hf |-> !fb_offset[0]) else $error("fb_offset");
    a_misc_write: assert property (w6 |=> ##1 graphics_mode == $past(reg_wdata[0], 2)
        && m == $past(reg_wdata[3:2], 2)) else $error("misc");
    a_misc_hold: assert property (!w6 && !$past(w6) |=> $stable(graphics_mode) && $stable(m)) else $error("misc");
    a_resv_zero: assert property (reg_rd && reg_index[7:1] == 7'h03 |=> !reg_rdata[7:4])
        else $error("reserved");
endmodule // vgamm_props
bind vgamm_regs vgamm_props vgamm_props_i (.*);

// ### tb/vgamm_regs_tb_top.sv
// Bench for the memory map and colour compare block.
`timescale 1ns/1ns
module vgamm_regs_tb_top;
    localparam [79:0] AT = {20'h9ffff, 20'hb8010, 20'hb0010, 20'ha0010};
    reg         clk = 0, resetn = 0, pci_mem_enable = 0, misc_output_ram_enable = 0, read_mode_one = 0;
    reg         cpu_mem_valid = 0;
    reg  [3:0]  color_compare_value = 4'h9;
    reg  [19:0] cpu_addr = 20'h0;
    reg  [7:0]  plane0_data = 8'hf0, plane1_data = 8'hcc, plane2_data = 8'haa, plane3_data = 8'hff, d;
    wire [7:0]  reg_index, reg_wdata, reg_rdata, compare_result, pixel_write_mask;
    wire        reg_wr, reg_rd, reg_hit, fb_hit, graphics_mode;
    wire [16:0] fb_offset;
    wire [3:0]  plane_enable;
    wire [1:0]  memory_map;
    integer     fails = 0, tests_run = 0, cyc = 0, m, k;
    vgamm_host vgamm_host_i (.*);
    vgamm_regs vgamm_regs_i (.*);
    initial forever #4 clk = ~clk;
    always @(posedge clk) if (++cyc == 900) test_done(1);
    task chk(input [47:0] n, input [16:0] s, e);
        tests_run++;
        if (s !== e) $display("FAIL %0s exp %h seen %h", n, e, s);
        fails += (s !== e);
    endtask
    task dec(input [19:0] a, input [16:0] eo, input eh, input [3:0] pe);
        @(posedge clk) #1 cpu_addr = a;
        @(posedge clk) #1 chk("hit", fb_hit, eh);
        chk("plane", plane_enable, pe);
        if (eh) chk("offset", fb_offset, eo);
    endtask
    task cmpt(input r, input [7:0] g, e);
        vgamm_host_i.wr(8'h07, g);
        read_mode_one = r;
        @(posedge clk) #1 chk("cmp", compare_result, e);
    endtask
    task test_done(input integer t);
        fails += t;
        $display("tests_run %0d fails %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        #1 resetn = 1;
        {cpu_mem_valid, pci_mem_enable, misc_output_ram_enable} = 3'h7;
        vgamm_host_i.wr(8'h06, 8'hfb);
        vgamm_host_i.rd(8'h06, d);
        chk("misc", d, 8'h0b);
        chk("gfx", graphics_mode, 1'b1);
        for (m = 0; m < 4; m++)
        begin
            vgamm_host_i.wr(8'h06, {4'h0, m[1:0], 2'h0});
            @(posedge clk) #1 chk("map", memory_map, m[1:0]);
            for (k = 0; k < 4; k++)
                dec(AT[20*k +: 20], m ? {1'b0, AT[20*k +: 16]} : AT[20*k +: 17], m ? k == m - 1 : k < 3, 4'hf);
        end
        vgamm_host_i.wr(8'h06, 8'h02);
        dec(20'ha0011, 17'h10, 1'b1, 4'ha);
        // Each enable is dropped in turn; the last pass has all three set.
        for (k = 0; k < 4; k++)
        begin
            {cpu_mem_valid, pci_mem_enable, misc_output_ram_enable} = 3'h7 ^ (3'h4 >> k);
            dec(20'ha0010, 17'h10, k == 3, 4'h5);
        end
        cmpt(1'b0, 8'h01, 8'h10);
        cmpt(1'b1, 8'h01, 8'hf0);
        cmpt(1'b1, 8'h00, 8'hff);
        cmpt(1'b1, 8'hff, 8'h10);
        vgamm_host_i.rd(8'h07, d);
        chk("ignore", d, 8'h0f);
        vgamm_host_i.wr(8'h08, 8'h5a);
        vgamm_host_i.rd(8'h08, d);
        chk("wmask", d, 8'h5a);
        chk("wmhit", reg_hit, 1'b1);
        chk("wmout", pixel_write_mask, 8'h5a);
        vgamm_host_i.rd(8'h09, d);
        chk("nohit", reg_hit, 1'b0);
        chk("nodata", d, 8'h00);
        test_done(0);
    end
endmodule // vgamm_regs_tb_top
